// *** verilog/lbss_pkg.sv ***
// lbss_pkg: constants and carrier types for the legacy shadow steering
// block; assumes byte-wide configuration access and a 32-bit address.
`default_nettype none

package lbss_pkg;

  // ==========================================================
  // configuration space location
  // ==========================================================
  localparam logic [7:0]  CFG_BUS         = 8'h00;
  localparam logic [4:0]  CFG_DEV         = 5'h00;
  localparam logic [2:0]  CFG_FUNC        = 3'h0;
  localparam logic [11:0] OFF_ATTR_TOP    = 12'h090;
  localparam logic [11:0] OFF_ATTR_C0     = 12'h091;

  // ==========================================================
  // register layout and reset values
  // ==========================================================
  localparam int          UPPER_LSB       = 4;   // upper field bits 5:4
  localparam int          LOWER_LSB       = 0;   // lower field bits 1:0
  localparam int          RE_BIT          = 0;   // read-to-dram in a field
  localparam int          WE_BIT          = 1;   // write-to-dram in a field
  localparam logic [7:0]  ATTR_RESET      = 8'h00;
  localparam logic [7:0]  MASK_ATTR_TOP   = 8'h30;
  localparam logic [7:0]  MASK_ATTR_C0    = 8'h33;
  localparam int          NUM_SEGMENTS    = 13;  // across all seven maps
  localparam int          NUM_ATTR_REGS   = 7;

  // ==========================================================
  // address windows
  // ==========================================================
  localparam logic [31:0] LEGACY_LO       = 32'h000c_0000;
  localparam logic [31:0] LEGACY_HI       = 32'h000f_ffff;
  localparam logic [31:0] SEG_TOP_LO      = 32'h000f_0000;
  localparam logic [31:0] SEG_TOP_HI      = 32'h000f_ffff;
  localparam logic [31:0] SEG_C4_LO       = 32'h000c_4000;
  localparam logic [31:0] SEG_C4_HI       = 32'h000c_7fff;
  localparam logic [31:0] SEG_C0_LO       = 32'h000c_0000;
  localparam logic [31:0] SEG_C0_HI       = 32'h000c_3fff;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [1:0] {
    SRC_HOST      = 2'b00,  // host processor
    SRC_PCI_INIT  = 2'b01,  // pci initiator
    SRC_DOWNLINK  = 2'b10,  // downstream_legacy_link
    SRC_GFX_LOW   = 2'b11   // graphics port, low priority
  } lbss_src_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    lbss_src_t   src;
  } lbss_req_t;

  typedef struct packed {
    logic dram;     // claimed, sent to main memory
    logic down;     // forwarded to downstream link
    logic legacy;   // address inside 0c0000..0fffff
    logic covered;  // segment governed by these two registers
  } lbss_route_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [11:0] off;
    logic [7:0]  wdata;
  } lbss_cfg_t;

endpackage : lbss_pkg

`default_nettype wire

// *** verilog/lbss_attr_reg.sv ***
// lbss_attr_reg: one 8-bit attribute register with lockable fields.
// assumes the caller decodes the address; reserved bits stay zero.
`timescale 1ns/1ns
`default_nettype none

module lbss_attr_reg #(
  parameter logic [7:0] WMASK = 8'h00  // writable field bits
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // write side
  input  wire logic       we_i,
  input  wire logic       lock_i,
  input  wire logic [7:0] wdata_i,
  // stored value
  output logic      [7:0] value_o
);

  // ==========================================================
  // storage
  // ==========================================================
  // reserved bits never load, so they read as zero forever
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      value_o <= lbss_pkg::ATTR_RESET;
    end
    else if (we_i && !lock_i)
    begin
      value_o <= wdata_i & WMASK;
    end
  end

endmodule : lbss_attr_reg

`default_nettype wire

// *** verilog/lbss_steer.sv ***
// lbss_steer: decides dram or downstream for one access, given the
// selected 2-bit field. assumes same-cycle inputs, purely combinational.
`timescale 1ns/1ns
`default_nettype none

module lbss_steer (
  // access
  input  wire logic                 write_i,
  input  wire lbss_pkg::lbss_src_t  src_i,
  input  wire logic                 legacy_i,
  input  wire logic                 covered_i,
  input  wire logic [1:0]           field_i,
  // result
  output lbss_pkg::lbss_route_t     route_o
);

  // ==========================================================
  // decode
  // ==========================================================
  logic is_inbound;  // from link or graphics port
  logic bit_sel;     // read or write enable of the field

  always_comb
  begin
    is_inbound = (src_i == lbss_pkg::SRC_DOWNLINK) ||
                 (src_i == lbss_pkg::SRC_GFX_LOW);
    bit_sel    = write_i ? field_i[lbss_pkg::WE_BIT]
                         : field_i[lbss_pkg::RE_BIT];
    route_o.legacy  = legacy_i;
    route_o.covered = covered_i;
    if (!legacy_i)
    begin
      route_o.dram = 1'b1;  // ordinary memory, not steered here
    end
    else if (is_inbound)
    begin
      route_o.dram = 1'b1;  // attributes ignored inbound
    end
    else if (covered_i)
    begin
      route_o.dram = bit_sel;  // host and pci alike
    end
    else
    begin
      route_o.dram = 1'b0;  // segment of another map: stay downstream
    end
    route_o.down = !route_o.dram;
  end

endmodule : lbss_steer

`default_nettype wire

// *** verilog/lbss_top.sv ***
// lbss_top: legacy bios shadow steering for the two attribute maps at
// 0x90 and 0x91 of bus 0 device 0 function 0 configuration space.
// assumes config requests, memory requests and the trusted lock come
// from logic on clock_i; no synchronisers are needed.
`timescale 1ns/1ns
`default_nettype none

module lbss_top (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // trusted execution lock level
  input  wire logic                  trusted_lock_i,
  // configuration access
  input  wire logic                  cfg_valid_i,
  input  wire lbss_pkg::lbss_cfg_t   cfg_i,
  output logic                       cfg_ack_o,
  output logic                       cfg_hit_o,
  output logic [7:0]                 cfg_rdata_o,
  // memory access to steer
  input  wire logic                  req_valid_i,
  input  wire lbss_pkg::lbss_req_t   req_i,
  output logic                       route_valid_o,
  output lbss_pkg::lbss_route_t      route_o,
  // attribute values for neighbouring logic
  output logic [7:0]                 attr_top_o,
  output logic [7:0]                 attr_c0_o
);

  // ==========================================================
  // configuration decode
  // ==========================================================
  logic       fn_match;   // bus 0, device 0, function 0
  logic       sel_top;    // offset of the top map
  logic       sel_c0;     // offset of the c0 map
  logic       we_top;     // write strobe, top map
  logic       we_c0;      // write strobe, c0 map
  logic [7:0] attr_top;   // stored top map
  logic [7:0] attr_c0;    // stored c0 map

  // only the two maps of this block answer with a hit
  always_comb
  begin
    fn_match = (cfg_i.bus == lbss_pkg::CFG_BUS) &&
               (cfg_i.dev == lbss_pkg::CFG_DEV) &&
               (cfg_i.func == lbss_pkg::CFG_FUNC);
    sel_top  = fn_match && (cfg_i.off == lbss_pkg::OFF_ATTR_TOP);
    sel_c0   = fn_match && (cfg_i.off == lbss_pkg::OFF_ATTR_C0);
    we_top   = cfg_valid_i && cfg_i.write && sel_top;
    we_c0    = cfg_valid_i && cfg_i.write && sel_c0;
  end

  // ==========================================================
  // attribute registers
  // ==========================================================
  // top map: only the upper field is implemented
  lbss_attr_reg #(
    .WMASK   (lbss_pkg::MASK_ATTR_TOP)
  ) u_attr_top (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .we_i    (we_top),
    .lock_i  (trusted_lock_i),
    .wdata_i (cfg_i.wdata),
    .value_o (attr_top)
  );

  // c0 map: upper and lower fields
  lbss_attr_reg #(
    .WMASK   (lbss_pkg::MASK_ATTR_C0)
  ) u_attr_c0 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .we_i    (we_c0),
    .lock_i  (trusted_lock_i),
    .wdata_i (cfg_i.wdata),
    .value_o (attr_c0)
  );

  // ==========================================================
  // configuration answer
  // ==========================================================
  // one-cycle answer to every request; a miss reads zero so the
  // surrounding bridge can merge answers by or-ing them
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cfg_ack_o   <= 1'b0;
      cfg_hit_o   <= 1'b0;
      cfg_rdata_o <= 8'h00;
    end
    else
    begin
      cfg_ack_o <= cfg_valid_i;
      cfg_hit_o <= cfg_valid_i && (sel_top || sel_c0);
      if (cfg_valid_i && !cfg_i.write && sel_top)
      begin
        cfg_rdata_o <= attr_top;  // reserved bits already zero
      end
      else if (cfg_valid_i && !cfg_i.write && sel_c0)
      begin
        cfg_rdata_o <= attr_c0;
      end
      else
      begin
        cfg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================
  // segment lookup
  // ==========================================================
  logic        in_legacy;  // inside 0c0000..0fffff
  logic        in_top;     // 0f0000..0fffff
  logic        in_c4;      // 0c4000..0c7fff
  logic        in_c0;      // 0c0000..0c3fff
  logic [1:0]  field;      // field governing the address
  lbss_pkg::lbss_route_t next_route;

  // the other ten segments belong to maps not held here, so they
  // are reported uncovered and keep their reset steering
  always_comb
  begin
    in_legacy = (req_i.addr >= lbss_pkg::LEGACY_LO) &&
                (req_i.addr <= lbss_pkg::LEGACY_HI);
    in_top    = (req_i.addr >= lbss_pkg::SEG_TOP_LO) &&
                (req_i.addr <= lbss_pkg::SEG_TOP_HI);
    in_c4     = (req_i.addr >= lbss_pkg::SEG_C4_LO) &&
                (req_i.addr <= lbss_pkg::SEG_C4_HI);
    in_c0     = (req_i.addr >= lbss_pkg::SEG_C0_LO) &&
                (req_i.addr <= lbss_pkg::SEG_C0_HI);
    if (in_top)
    begin
      field = attr_top[lbss_pkg::UPPER_LSB +: 2];
    end
    else if (in_c4)
    begin
      field = attr_c0[lbss_pkg::UPPER_LSB +: 2];
    end
    else if (in_c0)
    begin
      field = attr_c0[lbss_pkg::LOWER_LSB +: 2];
    end
    else
    begin
      field = 2'b00;
    end
  end

  // field to route decode, shared by every source
  lbss_steer u_steer (
    .write_i   (req_i.write),
    .src_i     (req_i.src),
    .legacy_i  (in_legacy),
    .covered_i (in_top || in_c4 || in_c0),
    .field_i   (field),
    .route_o   (next_route)
  );

  // ==========================================================
  // route output register
  // ==========================================================
  // one cycle from request to route; route holds until the next one
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      route_valid_o <= 1'b0;
      route_o       <= '0;
    end
    else
    begin
      route_valid_o <= req_valid_i;
      if (req_valid_i)
      begin
        route_o <= next_route;
      end
    end
  end

  // ==========================================================
  // attribute mirror outputs
  // ==========================================================
  // registered copy so every top output comes from a flip-flop;
  // costs one cycle of lag against the configuration write
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      attr_top_o <= lbss_pkg::ATTR_RESET;
      attr_c0_o  <= lbss_pkg::ATTR_RESET;
    end
    else
    begin
      attr_top_o <= attr_top;
      attr_c0_o  <= attr_c0;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic host_like;  // host or pci initiator
  assign host_like = (req_i.src == lbss_pkg::SRC_HOST) ||
                     (req_i.src == lbss_pkg::SRC_PCI_INIT);

  chk_reset_fields: assert property (
    $past(rst_i) |-> (attr_top == 8'h00) && (attr_c0 == 8'h00))
    else $error("attribute fields not zero after reset");

  chk_lock_freezes: assert property (
    (cfg_valid_i && cfg_i.write && (sel_top || sel_c0) && trusted_lock_i)
      |=> $stable(attr_top) && $stable(attr_c0))
    else $error("locked attribute register changed");

  chk_write_loads: assert property (
    (we_c0 && !trusted_lock_i)
      |=> attr_c0 == ($past(cfg_i.wdata) & lbss_pkg::MASK_ATTR_C0))
    else $error("c0 map did not take the write");

  chk_top_reserved: assert property (
    (attr_top[3:0] == 4'h0) && (attr_top[7:6] == 2'b00))
    else $error("top map reserved bits set");

  chk_c0_reserved: assert property (
    (attr_c0[7:6] == 2'b00) && (attr_c0[3:2] == 2'b00))
    else $error("c0 map reserved bits set");

  chk_read_to_dram: assert property (
    (req_valid_i && host_like && !req_i.write && in_c0)
      |=> route_valid_o && (route_o.dram == $past(attr_c0[0]))
          && (route_o.down == !$past(attr_c0[0])))
    else $error("read steering does not follow read bit");

  chk_write_to_dram: assert property (
    (req_valid_i && host_like && req_i.write && in_c4)
      |=> route_valid_o && (route_o.dram == $past(attr_c0[5])))
    else $error("write steering does not follow write bit");

  chk_field_decode: assert property (
    (req_valid_i && host_like && in_top
      && (attr_top[5:4] == 2'b10))
      |=> route_o.dram == $past(req_i.write))
    else $error("write-only field decoded wrongly");

  chk_pci_same: assert property (
    (req_valid_i && (req_i.src == lbss_pkg::SRC_PCI_INIT) && in_top
      && (attr_top[5:4] == 2'b00))
      |=> route_o.down && route_o.covered)
    else $error("pci initiator not steered like host");

  chk_inbound_dram: assert property (
    (req_valid_i && in_legacy && !host_like)
      |=> route_o.dram && !route_o.down && route_o.legacy)
    else $error("inbound legacy access not sent to dram");

  chk_cfg_answer: assert property (
    (cfg_valid_i && !cfg_i.write && sel_c0)
      |=> cfg_ack_o && cfg_hit_o && (cfg_rdata_o == $past(attr_c0)))
    else $error("c0 map read answered wrongly");

  cov_read_dram: cover property (
    req_valid_i && host_like && !req_i.write && in_c0 ##1 route_o.dram);
  cov_locked_write: cover property (
    we_top && trusted_lock_i);
  cov_inbound: cover property (
    req_valid_i && (req_i.src == lbss_pkg::SRC_DOWNLINK) && in_top);
  cov_full_dram: cover property (
    attr_top[5:4] == 2'b11 && attr_c0 == 8'h33);

endmodule : lbss_top

`default_nettype wire

// *** verification/lbss_far_model.sv ***
// ==========================================================
// lbss_far_model: far side of the steering block
// ==========================================================
// counts the accesses that the block hands to main memory and to the
// downstream_legacy_link; assumes route_o is settled while valid is high.
`timescale 1ns/1ns
`default_nettype none

module lbss_far_model (
  // clock
  input  wire logic                  clock_i,
  // steering result
  input  wire logic                  route_valid_i,
  input  wire lbss_pkg::lbss_route_t route_i,
  // tallies
  output int                         dram_seen_o,
  output int                         down_seen_o
);
  // one claim per pulse; a stuck valid or a double claim shows up here
  int dram_cnt = 0;  // claims taken by main memory
  int down_cnt = 0;  // claims forwarded downstream

  assign dram_seen_o = dram_cnt;
  assign down_seen_o = down_cnt;

  // each side takes only what is sent to it
  always @(posedge clock_i)
  begin
    if (route_valid_i === 1'b1)
    begin
      if (route_i.dram === 1'b1) dram_cnt <= dram_cnt + 1;
      if (route_i.down === 1'b1) down_cnt <= down_cnt + 1;
    end
  end
endmodule : lbss_far_model

`default_nettype wire

// *** verification/legacy_bios_shadow_steering_tb.sv ***
// ==========================================================
// legacy_bios_shadow_steering_tb: self-checking bench
// ==========================================================
// drives config and steering requests at the falling edge; the design
// answers at the rising edge that takes a request, checked at the next falling edge.
`timescale 1ns/1ns
`default_nettype none

module legacy_bios_shadow_steering_tb;
  // design signals
  logic                  clock_i;
  logic                  rst_i;
  logic                  trusted_lock_i;
  logic                  cfg_valid_i;
  lbss_pkg::lbss_cfg_t   cfg_i;
  logic                  cfg_ack_o;
  logic                  cfg_hit_o;
  logic [7:0]            cfg_rdata_o;
  logic                  req_valid_i;
  lbss_pkg::lbss_req_t   req_i;
  logic                  route_valid_o;
  lbss_pkg::lbss_route_t route_o;
  logic [7:0]            attr_top_o;
  logic [7:0]            attr_c0_o;
  // bookkeeping
  int                    failures;
  int                    checked;
  int                    exp_dram;
  int                    exp_down;
  int                    dram_seen;
  int                    down_seen;

  lbss_top dut (
    .clock_i(clock_i), .rst_i(rst_i), .trusted_lock_i(trusted_lock_i),
    .cfg_valid_i(cfg_valid_i), .cfg_i(cfg_i), .cfg_ack_o(cfg_ack_o),
    .cfg_hit_o(cfg_hit_o), .cfg_rdata_o(cfg_rdata_o),
    .req_valid_i(req_valid_i), .req_i(req_i),
    .route_valid_o(route_valid_o), .route_o(route_o),
    .attr_top_o(attr_top_o), .attr_c0_o(attr_c0_o)
  );

  lbss_far_model far (
    .clock_i(clock_i), .route_valid_i(route_valid_o), .route_i(route_o),
    .dram_seen_o(dram_seen), .down_seen_o(down_seen)
  );

  // ==========================================================
  // clock and checking helpers
  // ==========================================================
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_route(input lbss_pkg::lbss_route_t got,
                           input lbss_pkg::lbss_route_t exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: route got %b want %b", $time, got, exp);
    end
  endtask : cmp_route

  // one config cycle; ack, hit and data are looked at in their one cycle
  task automatic cfg_xfer(input logic wr, input logic [11:0] off,
                          input logic [7:0] wd, input logic hit_exp,
                          input logic [7:0] rd_exp);
    @(negedge clock_i);
    cfg_valid_i = 1'b1;
    cfg_i = '{write: wr, bus: 8'h00, dev: 5'h00, func: 3'h0,
              off: off, wdata: wd};
    @(negedge clock_i);
    cfg_valid_i = 1'b0;
    cmp_byte({7'h00, cfg_ack_o}, 8'h01, "cfg ack");
    cmp_byte({7'h00, cfg_hit_o}, {7'h00, hit_exp}, "cfg hit");
    cmp_byte(cfg_rdata_o, rd_exp, "cfg rdata");
  endtask : cfg_xfer

  // one access to steer, judged against the expected route
  task automatic steer(input logic [31:0] a, input logic wr,
                       input lbss_pkg::lbss_src_t s,
                       input lbss_pkg::lbss_route_t exp);
    @(negedge clock_i);
    req_valid_i = 1'b1;
    req_i = '{addr: a, write: wr, src: s};
    @(negedge clock_i);
    req_valid_i = 1'b0;
    cmp_byte({7'h00, route_valid_o}, 8'h01, "route valid");
    cmp_route(route_o, exp);
    if (exp.dram) exp_dram++;
    if (exp.down) exp_down++;
  endtask : steer

  // inbound sources ignore the field; host and pci follow it
  function automatic lbss_pkg::lbss_route_t exp_route(
      input logic [1:0] f, input logic wr, input logic [1:0] s,
      input logic cov);
    logic d;
    d = s[1] ? 1'b1 : (wr ? f[1] : f[0]);
    return '{dram: d, down: ~d, legacy: 1'b1, covered: cov};
  endfunction : exp_route

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    cmp_byte(attr_top_o, 8'h00, "top after reset");
    cmp_byte(attr_c0_o, 8'h00, "c0 after reset");
    cfg_xfer(1'b0, 12'h090, 8'h00, 1'b1, 8'h00);
    cfg_xfer(1'b0, 12'h091, 8'h00, 1'b1, 8'h00);
    steer(32'h000f_8000, 1'b1, lbss_pkg::SRC_HOST, exp_route(2'b00, 1'b1, 2'd0, 1'b1));
  endtask : t_reset

  // reserved bits read zero; a neighbour offset is a miss
  task automatic t_masks();
    cfg_xfer(1'b1, 12'h090, 8'hff, 1'b1, 8'h00);
    cfg_xfer(1'b0, 12'h090, 8'h00, 1'b1, 8'h30);
    cfg_xfer(1'b1, 12'h091, 8'hff, 1'b1, 8'h00);
    cfg_xfer(1'b0, 12'h091, 8'h00, 1'b1, 8'h33);
    cmp_byte(attr_c0_o, 8'h33, "c0 copy");
    cmp_byte(attr_top_o, 8'h30, "top copy");
    cfg_xfer(1'b0, 12'h092, 8'h00, 1'b0, 8'h00);
  endtask : t_masks

  // every field code against every region edge, direction and source
  task automatic t_decode();
    logic [31:0] addrs [6];
    addrs = '{32'h000c_0000, 32'h000c_3fff, 32'h000c_4000,
              32'h000c_7fff, 32'h000f_0000, 32'h000f_ffff};
    for (int f = 0; f < 4; f++)
    begin
      cfg_xfer(1'b1, 12'h090, {2'b00, f[1:0], 4'h0}, 1'b1, 8'h00);
      cfg_xfer(1'b1, 12'h091, {2'b00, f[1:0], 2'b00, f[1:0]}, 1'b1, 8'h00);
      for (int i = 0; i < 6; i++)
        for (int s = 0; s < 4; s++)
          for (int w = 0; w < 2; w++)
            steer(addrs[i], w[0], lbss_pkg::lbss_src_t'(s[1:0]), exp_route(f[1:0], w[0], s[1:0], 1'b1));
    end
  endtask : t_decode

  // a lower field alone must not steer the upper region
  task automatic t_split();
    cfg_xfer(1'b1, 12'h091, 8'h03, 1'b1, 8'h00);
    steer(32'h000c_3ff0, 1'b0, lbss_pkg::SRC_HOST,
          exp_route(2'b11, 1'b0, 2'd0, 1'b1));
    steer(32'h000c_4000, 1'b0, lbss_pkg::SRC_HOST,
          exp_route(2'b00, 1'b0, 2'd0, 1'b1));
    steer(32'h000c_8000, 1'b0, lbss_pkg::SRC_PCI_INIT,
          exp_route(2'b00, 1'b0, 2'd1, 1'b0));
    steer(32'h000e_0000, 1'b1, lbss_pkg::SRC_DOWNLINK,
          exp_route(2'b00, 1'b1, 2'd2, 1'b0));
    // just below the legacy range: plain memory, never steered
    steer(32'h000b_fffc, 1'b0, lbss_pkg::SRC_HOST,
          '{dram: 1'b1, down: 1'b0, legacy: 1'b0, covered: 1'b0});
    // software opens a segment fully before an inbound access to it
    cfg_xfer(1'b1, 12'h091, 8'h33, 1'b1, 8'h00);
    steer(32'h000c_4000, 1'b1, lbss_pkg::SRC_GFX_LOW,
          exp_route(2'b11, 1'b1, 2'd3, 1'b1));
  endtask : t_split

  // lock freezes the fields but leaves reads and steering alone
  task automatic t_lock();
    cfg_xfer(1'b1, 12'h091, 8'h30, 1'b1, 8'h00);
    @(negedge clock_i);
    trusted_lock_i = 1'b1;
    cfg_xfer(1'b1, 12'h091, 8'h03, 1'b1, 8'h00);
    // top map holds 30; a locked write of 00 must not clear it
    cfg_xfer(1'b1, 12'h090, 8'h00, 1'b1, 8'h00);
    cfg_xfer(1'b0, 12'h091, 8'h00, 1'b1, 8'h30);
    cfg_xfer(1'b0, 12'h090, 8'h00, 1'b1, 8'h30);
    steer(32'h000c_0000, 1'b0, lbss_pkg::SRC_HOST,
          exp_route(2'b00, 1'b0, 2'd0, 1'b1));
    @(negedge clock_i);
    trusted_lock_i = 1'b0;
    cfg_xfer(1'b1, 12'h091, 8'h00, 1'b1, 8'h00);
    cfg_xfer(1'b0, 12'h091, 8'h00, 1'b1, 8'h00);
  endtask : t_lock

  // ==========================================================
  // run control
  // ==========================================================
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // the whole run needs about 470 cycles; this is a wide margin
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end

  initial
  begin
    failures = 0;
    checked = 0;
    exp_dram = 0;
    exp_down = 0;
    rst_i = 1'b1;
    trusted_lock_i = 1'b0;
    cfg_valid_i = 1'b0;
    cfg_i = '0;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    t_reset();
    t_masks();
    t_decode();
    t_split();
    t_lock();
    @(negedge clock_i);
    cmp_byte(8'(dram_seen), 8'(exp_dram), "dram claims");
    cmp_byte(8'(down_seen), 8'(exp_down), "downstream claims");
    wrap_up();
  end
endmodule : legacy_bios_shadow_steering_tb

`default_nettype wire
